// File: core/mem_ctrl_consts.svh
`ifndef MEM_CTRL_CONSTS_SVH
`define MEM_CTRL_CONSTS_SVH

// strap codes on clk_select_straps
`define CLK_SEL_EXT 2'h0
`define CLK_SEL_DIV4 2'h1
`define CLK_SEL_DIV6 2'h2
// core clock divide figures
`define CORE_DIV_A 4
`define CORE_DIV_B 6
// output divider ratio codes
`define OUT_RATIO_1 2'h0
`define OUT_RATIO_2 2'h1
`define OUT_RATIO_4 2'h2
// read_en_select values
`define RES_ADDR_STROBE 1'h0
`define RES_READ_EN 1'h1
// space that owns the dedicated sync output enable
`define FIFO_SPACE 2'h3
// reset values
`define RATIO_RESET 2'h0
`define DIV_CNT_RESET 3'h0

`endif

// File: core/mem_ctrl_pkg.sv
package mem_ctrl_pkg;

	typedef enum logic [1:0]
	{
		mem_async = 2'h0,
		mem_sdram = 2'h1,
		mem_sync = 2'h2
	} mem_kind_type;

	typedef enum logic [2:0]
	{
		ph_strobe = 3'h0,
		ph_read = 3'h1,
		ph_write = 3'h2,
		ph_cmd_act = 3'h3,
		ph_cmd_rw = 3'h4
	} phase_type;

	// one access as the sequencer presents it
	typedef struct packed
	{
		logic active;
		mem_kind_type kind;
		logic [1:0] space;
		logic write;
		logic read_en_select;
		phase_type phase;
	} access_type;

	// strobe pins, active low
	typedef struct packed
	{
		logic read_strobe_n;
		logic output_en_n;
		logic write_en_n;
		logic space3_oe_n;
	} strobe_type;

	typedef enum logic [3:0]
	{
		st_idle = 4'b0001,
		st_busy = 4'b0010,
		st_drain = 4'b0100,
		st_held = 4'b1000
	} arb_state_type;

endpackage : mem_ctrl_pkg

// File: core/mem_ctrl.sv
`timescale 1ns/10ps
`include "mem_ctrl_consts.svh"
module mem_ctrl
	import mem_ctrl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// clock selection
	input wire logic if_clk_in,
	input wire logic [1:0] clk_select_straps,
	input wire logic [1:0] out_ratio,
	// access from the sequencer
	input wire access_type access,
	output logic access_done,
	// arbitration
	input wire logic hold_req_in,
	output logic hold_ack_out,
	output logic bus_req_out,
	output logic bus_out_en,
	// memory side
	input wire logic async_ready_in,
	output strobe_type strobes,
	output logic sdram_clk_en,
	input wire logic sdram_present,
	input wire logic self_refresh,
	input wire logic gp_out_level,
	// interface clocks
	output logic if_clk_out_full,
	output logic if_clk_out_div
);

	logic [1:0] sel_q, sel_d;
	logic sel_done_q, sel_done_d;
	logic [2:0] core_cnt_q, core_cnt_d;
	logic core_clk_q, core_clk_d;
	logic [1:0] ext_q, ext_d;
	logic if_tick;
	logic if_clk_level;
	logic [1:0] out_cnt_q, out_cnt_d;
	logic div_clk_q, div_clk_d;
	logic full_clk_q, full_clk_d;

	// straps caught by a clocked process after release
	// read once; a later strap change waits for the next reset
	always_comb
	begin
		sel_d = sel_q;
		sel_done_d = 1'b1;
		if (!sel_done_q)
		begin
			if (clk_select_straps == `CLK_SEL_DIV4 || clk_select_straps == `CLK_SEL_DIV6)
				sel_d = clk_select_straps;
			else
				sel_d = `CLK_SEL_EXT;
		end
	end

	// core divide: half period counts derived from the figures
	logic [2:0] half_cnt;
	always_comb
	begin
		half_cnt = (sel_q == `CLK_SEL_DIV6) ? 3'((`CORE_DIV_B / 2) - 1) :
			3'((`CORE_DIV_A / 2) - 1);
		core_cnt_d = core_cnt_q + 3'h1;
		core_clk_d = core_clk_q;
		if (core_cnt_q >= half_cnt)
		begin
			core_cnt_d = `DIV_CNT_RESET;
			core_clk_d = ~core_clk_q;
		end
		ext_d = {ext_q[0], if_clk_in};
	end

	// ext_q[0] only feeds ext_q[1]; edges are seen from the second stage
	logic ext_prev_q;
	logic ext_prev_d;
	assign ext_prev_d = ext_q[1];
	// core source from its next value so both output clocks move on one edge
	assign if_clk_level = (sel_q == `CLK_SEL_EXT) ? ext_q[1] : core_clk_d;
	assign if_tick = (sel_q == `CLK_SEL_EXT) ? (ext_q[1] & ~ext_prev_q) :
		(core_clk_d & ~core_clk_q);

	// output clocks follow the selected interface clock
	always_comb
	begin
		full_clk_d = if_clk_level;
		out_cnt_d = out_cnt_q;
		div_clk_d = div_clk_q;
		if (if_tick)
		begin
			out_cnt_d = out_cnt_q + 2'h1;
			unique case (out_ratio)
				`OUT_RATIO_2: div_clk_d = out_cnt_q[0];
				`OUT_RATIO_4: div_clk_d = out_cnt_q[1];
				// ratio one rises on each tick; the unused code parks high
				default: div_clk_d = 1'b1;
			endcase
		end
		else if (out_ratio == `OUT_RATIO_1 && !if_clk_level)
			div_clk_d = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			sel_q <= `CLK_SEL_EXT;
			sel_done_q <= 1'b0;
			core_cnt_q <= `DIV_CNT_RESET;
			core_clk_q <= 1'b0;
			ext_q <= 2'h0;
			ext_prev_q <= 1'b0;
			out_cnt_q <= 2'h0;
			div_clk_q <= 1'b0;
			full_clk_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_d;
			sel_done_q <= sel_done_d;
			core_cnt_q <= core_cnt_d;
			core_clk_q <= core_clk_d;
			ext_q <= ext_d;
			ext_prev_q <= ext_prev_d;
			out_cnt_q <= out_cnt_d;
			div_clk_q <= div_clk_d;
			full_clk_q <= full_clk_d;
		end
	end

	assign if_clk_out_full = full_clk_q;
	assign if_clk_out_div = div_clk_q;

	// arbitration
	arb_state_type arb_q, arb_d;
	logic ack_q, ack_d;
	logic breq_q, breq_d;
	logic oe_q, oe_d;

	always_comb
	begin
		arb_d = arb_q;
		ack_d = ack_q;
		breq_d = 1'b0;
		oe_d = oe_q;
		unique case (arb_q)
			st_idle:
			begin
				oe_d = 1'b1;
				if (hold_req_in)
					arb_d = st_drain;
				else if (access.active)
					arb_d = st_busy;
			end
			st_busy:
				if (access_done)
					arb_d = hold_req_in ? st_drain : st_idle;
			st_drain:
			begin
				// float first, acknowledge one cycle later
				oe_d = 1'b0;
				if (!oe_q)
				begin
					ack_d = 1'b1;
					arb_d = st_held;
				end
			end
			st_held:
			begin
				// host owns the bus; we only flag that we need it back
				breq_d = access.active;
				if (!hold_req_in)
				begin
					ack_d = 1'b0;
					arb_d = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			arb_q <= st_idle;
			ack_q <= 1'b0;
			breq_q <= 1'b0;
			oe_q <= 1'b1;
		end
		else
		begin
			arb_q <= arb_d;
			ack_q <= ack_d;
			breq_q <= breq_d;
			oe_q <= oe_d;
		end
	end

	assign hold_ack_out = ack_q;
	assign bus_req_out = breq_q;
	assign bus_out_en = oe_q;

	// strobe decode; the sequencer steps phases, we only hold the strobe
	strobe_type strb_q, strb_d;
	logic done_q, done_d;
	logic cke_q, cke_d;
	logic go;

	// accesses start only from busy, so none begins under hold
	assign go = access.active && (arb_q == st_busy);

	always_comb
	begin
		strb_d = '{read_strobe_n: 1'b1, output_en_n: 1'b1, write_en_n: 1'b1,
			space3_oe_n: 1'b1};
		done_d = 1'b0;
		if (go)
		begin
			unique case (access.kind)
				mem_async:
				begin
					strb_d.read_strobe_n = access.write;
					strb_d.output_en_n = access.write;
					strb_d.write_en_n = ~access.write;
					if (if_tick)
					begin
						// not ready: hold strobe another interface cycle
						done_d = async_ready_in && !done_q;
					end
				end
				mem_sdram:
				begin
					strb_d.read_strobe_n = (access.phase != ph_cmd_rw);
					strb_d.output_en_n = (access.phase != ph_cmd_act);
					strb_d.write_en_n = !(access.write && access.phase == ph_cmd_rw);
					done_d = if_tick && !done_q;
				end
				mem_sync:
				begin
					if (access.read_en_select == `RES_READ_EN)
						strb_d.read_strobe_n = access.write;
					else
						strb_d.read_strobe_n = (access.phase != ph_strobe);
					strb_d.output_en_n = access.write || (access.phase != ph_read);
					strb_d.write_en_n = !access.write;
					strb_d.space3_oe_n = !(access.space == `FIFO_SPACE &&
						!access.write && access.phase == ph_read);
					done_d = if_tick && !done_q;
				end
				default:
				begin
					// unknown kind: no strobe, but finish so the arbiter leaves busy
					done_d = if_tick && !done_q;
				end
			endcase
		end
		// sdram present: self-refresh drops the clock enable
		if (sdram_present)
			cke_d = ~self_refresh;
		else
			cke_d = gp_out_level;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			strb_q <= '{read_strobe_n: 1'b1, output_en_n: 1'b1, write_en_n: 1'b1,
				space3_oe_n: 1'b1};
			done_q <= 1'b0;
			cke_q <= 1'b1;
		end
		else
		begin
			strb_q <= strb_d;
			done_q <= done_d;
			cke_q <= cke_d;
		end
	end

	assign strobes = strb_q;
	assign access_done = done_q;
	assign sdram_clk_en = cke_q;

endmodule : mem_ctrl

// File: sim/mem_ctrl_monitor.sv
`timescale 1ns/10ps
`include "mem_ctrl_consts.svh"
module mem_ctrl_monitor
	import mem_ctrl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// access and arbitration
	input wire access_type access,
	input wire logic access_done,
	input wire logic hold_req_in,
	input wire logic hold_ack_out,
	input wire logic bus_req_out,
	input wire logic bus_out_en,
	// memory side
	input wire logic async_ready_in,
	input wire strobe_type strobes
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	a_ack_bus_float: assert property ($rose(hold_ack_out) |-> !bus_out_en)
		else $error("ack while driving");
	a_ack_needs_req: assert property ($rose(hold_ack_out) |-> $past(hold_req_in))
		else $error("ack without request");
	a_ack_drops: assert property (hold_ack_out && !hold_req_in |=> !hold_ack_out)
		else $error("ack stuck");
	a_ack_holds: assert property (hold_ack_out && hold_req_in |=> hold_ack_out)
		else $error("ack lost");
	a_busreq_cause: assert property (bus_req_out |-> $past(access.active))
		else $error("bus request idle");
	a_held_quiet: assert property (hold_ack_out |-> strobes.read_strobe_n && strobes.write_en_n)
		else $error("strobe while held");
	a_fifo_space: assert property (!strobes.space3_oe_n |-> $past(access.space) == `FIFO_SPACE)
		else $error("fifo oe wrong space");
	a_done_ready: assert property (access_done && access.kind == mem_async |-> $past(async_ready_in))
		else $error("done without ready");
	a_wait_extend: assert property (access.active && access.kind == mem_async &&
		!strobes.read_strobe_n && !async_ready_in |=> !strobes.read_strobe_n)
		else $error("strobe cut short");
	c_hold: cover property ($rose(hold_ack_out));
	c_done: cover property (access_done);
	c_fifo: cover property (!strobes.space3_oe_n);
	c_extend: cover property (access.active && access.kind == mem_async &&
		!strobes.read_strobe_n && !async_ready_in);
endmodule : mem_ctrl_monitor
bind mem_ctrl mem_ctrl_monitor mon (.sys_clk, .reset_n, .access, .access_done, .hold_req_in,
	.hold_ack_out, .bus_req_out, .bus_out_en, .async_ready_in, .strobes);

// File: sim/mem_far.sv
`timescale 1ns/10ps
module mem_far
	import mem_ctrl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// memory side
	input wire access_type access,
	input wire logic [2:0] waits,
	output logic async_ready_in,
	// host side
	input wire logic hold_go,
	output logic hold_req_in,
	input wire logic hold_ack_out
);
	logic [2:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, req_q, req_d;
	always_comb
	begin
		// saturate so ready never drops mid access
		cnt_d = access.active ? cnt_q + {2'h0, cnt_q != 3'h7} : 3'h0;
		rdy_d = access.active && cnt_q >= waits;
		// request kept up until answered
		req_d = hold_go || (req_q && !hold_ack_out);
	end
	always_ff @(posedge sys_clk)
	begin
		cnt_q <= reset_n ? cnt_d : 3'h0;
		rdy_q <= reset_n && rdy_d;
		req_q <= reset_n && req_d;
	end
	assign async_ready_in = rdy_q;
	assign hold_req_in = req_q;
endmodule : mem_far

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
	import mem_ctrl_pkg::*;
	logic sys_clk = 0, reset_n = 0, if_clk_in = 0, hold_go = 0;
	logic sdram_present = 0, self_refresh = 0, gp_out_level = 0, res_sel = 1;
	logic [1:0] clk_select_straps = 0, out_ratio = 0;
	logic [2:0] waits = 0;
	access_type access = '0;
	logic access_done, hold_req_in, hold_ack_out, bus_req_out, bus_out_en, async_ready_in;
	logic sdram_clk_en, if_clk_out_full, if_clk_out_div;
	strobe_type strobes;
	logic [7:0] notes[$];
	logic [7:0] note;
	int miscompares = 0, n_compared = 0, seed = 70884, t;
	initial forever #2.5 sys_clk = !sys_clk;
	always #20 if_clk_in = !if_clk_in;
	mem_ctrl uut (.sys_clk, .reset_n, .if_clk_in, .clk_select_straps, .out_ratio, .access,
		.access_done, .hold_req_in, .hold_ack_out, .bus_req_out, .bus_out_en, .async_ready_in,
		.strobes, .sdram_clk_en, .sdram_present, .self_refresh, .gp_out_level,
		.if_clk_out_full, .if_clk_out_div);
	mem_far far (.sys_clk, .reset_n, .access, .waits, .async_ready_in, .hold_go, .hold_req_in,
		.hold_ack_out);
	task check(input string what, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	function int near(input int n, e);
		return (n >= e - 1 && n <= e + 1) ? e : n;
	endfunction : near
	task clk_test(input logic [1:0] s, r, input int per);
		int nf, nd;
		logic pf, pd;
		clk_select_straps = s;
		out_ratio = r;
		reset_n = 0;
		cyc(5);
		reset_n = 1;
		cyc(20);
		{nf, nd, pf, pd} = '0;
		repeat (480)
		begin
			cyc(1);
			nf += int'(if_clk_out_full & !pf);
			nd += int'(if_clk_out_div & !pd);
			{pf, pd} = {if_clk_out_full, if_clk_out_div};
		end
		check("full", near(nf, 480 / per), 480 / per);
		check("div", near(nd, 480 / per / (1 << r)), 480 / per / (1 << r));
		$display("clock test %0d %0d done", s, r);
	endtask : clk_test
	// strobes watched at done: read, oe, write, fifo oe; notes carry mask and value
	task acc(input mem_kind_type k, input logic w, input logic [1:0] sp, input phase_type ph,
		input logic [3:0] exp, mask);
		notes.push_back({mask, exp});
		access = '{1'b1, k, sp, w, res_sel, ph};
		waits = 3'($random(seed));
		t = 0;
		while (access_done !== 1'b1 && t < 100)
		begin
			cyc(1);
			t++;
		end
		if (t == 100)
		begin
			miscompares++;
			tally_and_finish;
		end
		access.active = 0;
		cyc(1);
	endtask : acc
	always @(negedge sys_clk)
		if (reset_n && access_done === 1'b1)
		begin
			note = notes.pop_front();
			check("strobes", {4'h0, strobes & note[7:4]}, {4'h0, note[3:0]});
		end
	initial
	begin
		for (int i = 0; i < 9; i++)
			clk_test(i / 3, i % 3, i / 3 == 0 ? 8 : (i / 3 == 1 ? 4 : 6));
		for (int i = 0; i < 8; i++)
			acc(mem_async, i[0], 2'($random(seed)), ph_strobe, i[0] ? 4'hC : 4'h2, 4'hE);
		for (int i = 0; i < 4; i++)
			acc(mem_sync, 1'b0, i[1:0], ph_read, {3'h0, i != 3}, 4'h1);
		res_sel = 0;
		acc(mem_sync, 1'b0, 2'h0, ph_strobe, 4'h7, 4'hF);
		acc(mem_sync, 1'b0, 2'h3, ph_read, 4'hA, 4'hF);
		acc(mem_sync, 1'b1, 2'h3, ph_write, 4'hD, 4'hF);
		res_sel = 1;
		acc(mem_sdram, 1'b0, 2'h1, ph_cmd_act, 4'hB, 4'hF);
		acc(mem_sdram, 1'b1, 2'h1, ph_cmd_rw, 4'h5, 4'hF);
		acc(mem_sdram, 1'b0, 2'h1, ph_cmd_rw, 4'h7, 4'hF);
		$display("access test done");
		hold_go = 1;
		for (t = 0; hold_ack_out !== 1'b1 && t < 50; t++)
			cyc(1);
		if (t == 50)
		begin
			miscompares++;
			tally_and_finish;
		end
		access = '{1'b1, mem_async, 2'h1, 1'b0, 1'b1, ph_strobe};
		cyc(3);
		check("ack", hold_ack_out, 1);
		check("busreq", bus_req_out, 1);
		check("float", bus_out_en, 0);
		access.active = 0;
		hold_go = 0;
		cyc(4);
		check("release", {hold_ack_out, bus_out_en}, 1);
		$display("hold test done");
		for (int i = 0; i < 8; i++)
		begin
			{sdram_present, self_refresh, gp_out_level} = i[2:0];
			cyc(2);
			check("cke", sdram_clk_en, i[2] ? !i[1] : i[0]);
		end
		$display("clock enable test done");
		tally_and_finish;
	end
endmodule : tb
